//--- interrupt_driven_transfer_engine_tb_top.sv
// Self-checking bench for the transfer engine with a memory model.
// Assumes the engine's constants header and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "itde_defs.svh"
module interrupt_driven_transfer_engine_tb_top import itde_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ins = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [1:0] ext_req_pin = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, busy, mem_ack;
  logic [13:0] periph_flag = 14'h0;
  logic [13:0] raise = 14'h0;
  logic [13:0] flag_clear;
  logic [15:0] cpu_irq_ack = 16'h0;
  logic [15:0] cpu_irq_req, mem_rdata;
  logic [7:0] cpu_entry_states;
  itde_mem_req_t mem_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc;
  localparam logic [7:0] VMIN [16] = '{8'h80, 8'h82, 8'h88, 8'h8a, 8'h8c, 8'h90, 8'h92,
    8'h94, 8'h98, 8'h9a, 8'h9c, 8'ha0, 8'ha2, 8'haa, 8'hac, 8'hb0};

  always #25 clk = ~clk;
  // Peripheral flags: set by the bench, cleared by the engine
  always @(posedge clk) periph_flag <= (periph_flag | raise) & ~flag_clear;
  always @(posedge clk) ins <= 1'($urandom % 2);

  itde_engine dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .periph_flag(periph_flag),
    .ext_req_pin(ext_req_pin), .cpu_insn_done(ins), .cpu_irq_ack(cpu_irq_ack),
    .cpu_irq_req(cpu_irq_req), .cpu_entry_states(cpu_entry_states), .flag_clear(flag_clear),
    .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));
  itde_mem_model mem_u (.clk(clk), .rst_n(rst_n), .m(mem_out), .rdata(mem_rdata),
    .ack(mem_ack));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single AHB-Lite transfer, address then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [15:0] rw(input logic [15:0] a);
    return {mem_u.mem[a], mem_u.mem[a + 16'h1]};
  endfunction
  task automatic ww(input logic [15:0] a, input logic [15:0] d);
    mem_u.mem[a] = d[15:8];
    mem_u.mem[a + 16'h1] = d[7:0];
  endtask
  task automatic wait_busy(input logic v);
    cyc = 0;
    while (busy !== v && cyc < 400) begin
      @(posedge clk);
      cyc++;
    end
    chk("busy", 32'(v), 32'(busy));
  endtask
  // Least number of states one transfer may take; source data always in RAM
  function automatic int n_states(input logic [15:0] cb, input logic [15:0] da,
                                  input logic [15:0] md);
    int n;
    n = 26 + 2 * md[14] + 2 * md[13] + 2;
    n += (da >= `ITDE_REG_FIELD_BASE) ? (md[15] ? 6 : 3) : 2;
    if (cb < `ITDE_RAM_LO_DEF) n += 20 + 4 * md[14] + 4 * md[13];
    return n;
  endfunction
  // One whole transfer for source s, then its side effects
  task automatic xfer(input int s, input logic mx, input logic [15:0] cnt);
    logic [15:0] cb, va, md, sa, da, dat, inc;
    cb = 16'(s * 8) + ((s % 4 == 2) ? 16'h4000 : 16'hfc00); // External block now and then
    va = mx ? {7'h0, VMIN[s], 1'b0} + 16'h2 : {8'h0, VMIN[s]};
    md = {3'($urandom), 13'h0};
    sa = 16'hf800 + 16'(s * 16);
    da = (s % 4 == 3) ? `ITDE_REG_FIELD_BASE + 16'(s * 4) : 16'hfa00 + 16'(s * 16);
    dat = 16'($urandom);
    inc = md[15] ? 16'h2 : 16'h1;
    if (mx) ww(va - 16'h2, 16'hdead);
    ww(va, cb);
    ww(cb, md);
    ww(cb + 16'h2, sa);
    ww(cb + 16'h4, da);
    ww(cb + 16'h6, cnt);
    ww(sa, dat);
    ww(da, ~dat);
    bus(1'b1, `ITDE_OFS_CTRL, {30'h0, mx, 1'b1});
    bus(1'b1, `ITDE_OFS_ENABLE, 32'h1 << s);
    chk("entry states", mx ? 32'd21 : 32'd16, 32'(cpu_entry_states));
    if (s < 2) ext_req_pin[s] <= 1'b1;
    else raise[s - 2] <= 1'b1;
    @(posedge clk);
    raise <= 14'h0;
    ext_req_pin <= 2'b00;
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk("length", 32'h1, 32'(cyc >= n_states(cb, da, md)));
    chk("src ptr", md[14] ? sa + inc : sa, rw(cb + 16'h2));
    chk("dst ptr", md[13] ? da + inc : da, rw(cb + 16'h4));
    chk("count", 32'(16'(cnt - 16'h1)), 32'(rw(cb + 16'h6)));
    chk("data", md[15] ? dat : {dat[15:8], ~dat[7:0]}, rw(da));
    repeat (3) @(posedge clk);
    chk("done irq", 32'(cnt == 16'h1), 32'(cpu_irq_req[s]));
    chk("no restart", 32'h0, 32'(busy));
    if (s >= 2) chk("flag", 32'h0, 32'(periph_flag[s - 2]));
    cpu_irq_ack[s] <= 1'b1;
    @(posedge clk);
    cpu_irq_ack <= 16'h0;
    repeat (2) @(posedge clk);
    chk("irq ack", 32'h0, 32'(cpu_irq_req[s]));
    bus(1'b0, `ITDE_OFS_ENABLE, 32'h0);
    chk("enable kept", 32'h1 << s, rd);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #3000000;
    n_mismatch++;
    close_out;
  end

  initial begin
    logic [15:0] c;
    void'($urandom(32'h4f9c3a5d));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("resp", 32'h0, 32'(hresp));
    for (int s = 0; s < 16; s++) begin
      c = (s == 5) ? 16'h0 : (s % 3 == 0) ? 16'h1 : 16'(2 + $urandom % 5);
      xfer(s, 1'(s % 2), c);
    end
    bus(1'b0, `ITDE_OFS_XFERS, 32'h0);
    chk("xfers", 32'd16, rd);
    bus(1'b1, `ITDE_OFS_CTRL, 32'h25);
    repeat (2) @(posedge clk);
    chk("ext stack min", 32'd40, 32'(cpu_entry_states));
    bus(1'b1, `ITDE_OFS_CTRL, 32'h27);
    repeat (2) @(posedge clk);
    chk("ext stack max", 32'd61, 32'(cpu_entry_states));
    bus(1'b1, `ITDE_OFS_ENABLE, 32'h0);
    raise[1] <= 1'b1;
    @(posedge clk);
    raise <= 14'h0;
    repeat (4) @(posedge clk);
    chk("cpu route", 32'h1, 32'(cpu_irq_req[3]));
    chk("idle", 32'h0, 32'(busy));
    close_out;
  end
endmodule
`default_nettype wire

//--- itde_defs.svh
// Constants for the interrupt-driven transfer engine: addresses, field positions, state counts.
// Assumes page-0 16-bit addressing and a single 20 MHz system clock.
`ifndef ITDE_DEFS_SVH
`define ITDE_DEFS_SVH
`define ITDE_NUM_SRC 16
`define ITDE_NUM_EXT 2
// Transfer vector table bases, right after the exception vectors
`define ITDE_MIN_VEC_BASE 16'h0080
`define ITDE_MAX_VEC_BASE 16'h0100
`define ITDE_MAX_VEC_SKIP 16'h0002
`define ITDE_MIN_VEC_LAST 16'h00b0
// Table slot of each source, source 0 in the low five bits
`define ITDE_SLOT_TABLE {5'd24, 5'd22, 5'd21, 5'd17, 5'd16, 5'd14, 5'd13, 5'd12, \
                         5'd10, 5'd9, 5'd8, 5'd6, 5'd5, 5'd4, 5'd1, 5'd0}
// Control block word offsets
`define ITDE_CB_MODE 16'h0000
`define ITDE_CB_SRC 16'h0002
`define ITDE_CB_DST 16'h0004
`define ITDE_CB_CNT 16'h0006
// Mode word fields
`define ITDE_MODE_WORD 15
`define ITDE_MODE_SI 14
`define ITDE_MODE_DI 13
`define ITDE_INC_BYTE 16'h0001
`define ITDE_INC_WORD 16'h0002
// Memory regions
`define ITDE_REG_FIELD_BASE 16'hff80
`define ITDE_RAM_LO_DEF 16'hf680
`define ITDE_RAM_HI_DEF 16'hff7f
// State counts
`define ITDE_BASE_STATES 8'd26
`define ITDE_INC_STATES 8'd2
`define ITDE_RAM_ACC 8'd2
`define ITDE_EXT_BYTE 8'd3
`define ITDE_EXT_WORD 8'd6
`define ITDE_CB_EXT_BASE 8'd20
`define ITDE_CB_EXT_INC 8'd4
`define ITDE_PRIO_LAST 2'd1
`define ITDE_ENTRY_MIN_ON 8'd16
`define ITDE_ENTRY_MAX_ON 8'd21
`define ITDE_ENTRY_MIN_EXT 8'd28
`define ITDE_ENTRY_MIN_EXT_M 8'd6
`define ITDE_ENTRY_MAX_EXT 8'd41
`define ITDE_ENTRY_MAX_EXT_M 8'd10
// Register offsets on the bus
`define ITDE_OFS_CTRL 8'h00
`define ITDE_OFS_ENABLE 8'h04
`define ITDE_OFS_STATUS 8'h08
`define ITDE_OFS_XFERS 8'h0c
`define ITDE_CTRL_ON 0
`define ITDE_CTRL_MAX 1
`define ITDE_CTRL_STK 2
`define ITDE_CTRL_M_LO 4
`define ITDE_CTRL_M_HI 5
`endif

//--- itde_engine.sv
// Interrupt-driven transfer engine: routes requests, walks control blocks, moves one item.
// Assumes an AHB-Lite master, a memory port with req/ack handshake, synchronous inputs.
// Functional notes
// - Enabled source goes to the engine, disabled source goes to the CPU.
// - Transfer vector table follows exception vectors at start of page 0.
// - First step reads the control block address from the vector entry.
// - Minimum mode entry is two bytes holding a page-0 address.
// - Maximum mode entry is four bytes; last two used as page-0 address.
// - Entry addresses follow the fixed per-source slot map.
// - Control block is four consecutive words anywhere in page 0.
// - Load mode and source pointer, then read one byte or word.
// - Source increment enabled: bump pointer and write it back.
// - Load destination pointer and write the item there.
// - Destination increment enabled: bump pointer and write it back.
// - Load count, decrement by one, write it back every transfer.
// - Count now zero raises CPU interrupt of the starting source.
// - Starting count zero wraps, giving 65536 transfers.
// - Clear the peripheral flag, or the internal latch for external pins.
// - Transfer enable bits are never changed by the engine.
// - On-chip block: 26 states plus 2 per increment plus data states.
// - Data access: 2 on-chip, 3 byte or 6 word elsewhere.
// - Register field at top of page 0 timed as register access.
// - External block adds 20 plus 4 per increment.
// - Start after 2 priority states and the current instruction end.
// - Entry overhead 16/21 on-chip stack, 28+6m/41+10m external.
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "itde_defs.svh"
module itde_engine import itde_pkg::*; #(
  parameter logic [15:0] RAM_LO = `ITDE_RAM_LO_DEF,
  parameter logic [15:0] RAM_HI = `ITDE_RAM_HI_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [13:0] periph_flag,
  input wire logic [1:0] ext_req_pin,
  input wire logic cpu_insn_done,
  input wire logic [15:0] cpu_irq_ack,
  output logic [15:0] cpu_irq_req,
  output logic [7:0] cpu_entry_states,
  output logic [13:0] flag_clear,
  output itde_mem_req_t mem_out,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic busy
);
  localparam logic [79:0] SLOTS = `ITDE_SLOT_TABLE;
  itde_state_t state_reg, state_next;
  itde_mem_req_t mem_reg, mem_next;
  logic [15:0] cb_reg, cb_next, mode_reg, mode_next, src_reg, src_next;
  logic [15:0] dst_reg, dst_next, cnt_reg, cnt_next, data_reg, data_next;
  logic [3:0] idx_reg, idx_next;
  logic [1:0] prio_reg, prio_next;
  logic [7:0] elapsed;
  logic [15:0] te_reg, done_reg, done_next, cpu_irq_reg;
  logic [1:0] latch_reg, pin_prev_reg;
  logic [13:0] flag_clear_reg;
  logic [5:0] ctrl_reg;
  logic [31:0] xfers_reg, hrdata_reg;
  logic [7:0] entry_reg;
  logic bus_wr_reg, ready_reg, busy_reg;
  logic [7:0] bus_ofs_reg;

  // Request routing
  wire [15:0] req_vec = {periph_flag, latch_reg};
  wire [15:0] service = req_vec & te_reg;
  wire [15:0] to_cpu = req_vec & ~te_reg;
  wire engine_on = ctrl_reg[`ITDE_CTRL_ON];
  wire max_mode = ctrl_reg[`ITDE_CTRL_MAX];
  wire [1:0] wait_m = ctrl_reg[`ITDE_CTRL_M_HI:`ITDE_CTRL_M_LO];
  wire is_word = mode_reg[`ITDE_MODE_WORD];
  wire si = mode_reg[`ITDE_MODE_SI];
  wire di = mode_reg[`ITDE_MODE_DI];
  wire [15:0] inc = is_word ? `ITDE_INC_WORD : `ITDE_INC_BYTE;

  // Lowest numbered engine request wins
  function automatic logic [3:0] pick(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `ITDE_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Vector entry address from the slot map
  wire [4:0] slot = SLOTS[idx_reg * 5 +: 5];
  wire [15:0] vec_min = `ITDE_MIN_VEC_BASE + {10'h000, slot, 1'b0};
  wire [15:0] vec_max = `ITDE_MAX_VEC_BASE + {9'h000, slot, 2'b00}
                        + `ITDE_MAX_VEC_SKIP;
  wire [15:0] vec_addr = max_mode ? vec_max : vec_min;

  // Access cost of a data address
  function automatic logic [7:0] acc_states(input logic [15:0] a, input logic w);
    logic on_chip;
    on_chip = (a >= RAM_LO) && (a <= RAM_HI) && (a < `ITDE_REG_FIELD_BASE);
    return on_chip ? `ITDE_RAM_ACC : (w ? `ITDE_EXT_WORD : `ITDE_EXT_BYTE);
  endfunction

  // Transfer length in states
  wire cb_ext = (cb_reg < RAM_LO) || (cb_reg > RAM_HI);
  wire [7:0] inc_n = {7'h00, si} + {7'h00, di};
  wire [7:0] cb_extra = cb_ext ? (`ITDE_CB_EXT_BASE + 8'(inc_n * `ITDE_CB_EXT_INC))
                               : 8'h00;
  wire [7:0] budget = `ITDE_BASE_STATES + 8'(inc_n * `ITDE_INC_STATES)
                      + acc_states(src_reg, is_word) + acc_states(dst_reg, is_word)
                      + cb_extra;
  // One bit wider so a saturated timer cannot wrap and hold the engine forever
  wire finish_go = (state_reg == ITDE_FINISH) && ({1'b0, elapsed} + 9'h001 >= {1'b0, budget});

  // Address, direction and data of the access of each state
  wire mem_state = (state_reg >= ITDE_VEC) && (state_reg <= ITDE_WB_CNT);
  wire [15:0] op_addr =
    (state_reg == ITDE_VEC) ? vec_addr :
    (state_reg == ITDE_LD_MODE) ? cb_reg + `ITDE_CB_MODE :
    (state_reg == ITDE_LD_SRC || state_reg == ITDE_WB_SRC) ? cb_reg + `ITDE_CB_SRC :
    (state_reg == ITDE_RD_DATA) ? src_reg :
    (state_reg == ITDE_LD_DST || state_reg == ITDE_WB_DST) ? cb_reg + `ITDE_CB_DST :
    (state_reg == ITDE_WR_DATA) ? dst_reg :
    cb_reg + `ITDE_CB_CNT;
  wire op_we = (state_reg == ITDE_WB_SRC) || (state_reg == ITDE_WR_DATA) ||
               (state_reg == ITDE_WB_DST) || (state_reg == ITDE_WB_CNT);
  wire op_word = ((state_reg == ITDE_RD_DATA) || (state_reg == ITDE_WR_DATA)) ? is_word : 1'b1;
  wire [15:0] op_wdata =
    (state_reg == ITDE_WB_SRC) ? src_reg + inc :
    (state_reg == ITDE_WB_DST) ? dst_reg + inc :
    (state_reg == ITDE_WR_DATA) ? data_reg : cnt_reg;
  wire [15:0] rd_item = is_word ? mem_rdata : {8'h00, mem_rdata[7:0]};

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    mem_next = mem_reg;
    cb_next = cb_reg;
    mode_next = mode_reg;
    src_next = src_reg;
    dst_next = dst_reg;
    cnt_next = cnt_reg;
    data_next = data_reg;
    idx_next = idx_reg;
    prio_next = prio_reg;
    if (mem_state && !mem_reg.req) begin
      mem_next = '{req: 1'b1, we: op_we, word: op_word, addr: op_addr, wdata: op_wdata};
    end else if (mem_state && mem_ack) begin
      mem_next.req = 1'b0;
    end
    unique case (state_reg)
      ITDE_IDLE: begin
        if (engine_on && (service != 16'h0000)) begin
          idx_next = pick(service);
          prio_next = 2'd0;
          state_next = ITDE_PRIO;
        end
      end
      ITDE_PRIO: begin
        prio_next = prio_reg + 2'd1;
        if (prio_reg == `ITDE_PRIO_LAST) begin
          state_next = ITDE_WAIT_INSN;
        end
      end
      ITDE_WAIT_INSN: begin
        if (cpu_insn_done) begin
          state_next = ITDE_VEC;
        end
      end
      ITDE_FINISH: begin
        if (finish_go) begin
          state_next = ITDE_IDLE;
        end
      end
      default: begin
        if (mem_reg.req && mem_ack) begin
          unique case (state_reg)
            ITDE_VEC: begin
              cb_next = mem_rdata;
              state_next = ITDE_LD_MODE;
            end
            ITDE_LD_MODE: begin
              mode_next = mem_rdata;
              state_next = ITDE_LD_SRC;
            end
            ITDE_LD_SRC: begin
              src_next = mem_rdata;
              state_next = ITDE_RD_DATA;
            end
            ITDE_RD_DATA: begin
              data_next = rd_item;
              state_next = si ? ITDE_WB_SRC : ITDE_LD_DST;
            end
            ITDE_WB_SRC: begin
              src_next = src_reg + inc;
              state_next = ITDE_LD_DST;
            end
            ITDE_LD_DST: begin
              dst_next = mem_rdata;
              state_next = ITDE_WR_DATA;
            end
            ITDE_WR_DATA: begin
              state_next = di ? ITDE_WB_DST : ITDE_LD_CNT;
            end
            ITDE_WB_DST: begin
              dst_next = dst_reg + inc;
              state_next = ITDE_LD_CNT;
            end
            ITDE_LD_CNT: begin
              cnt_next = mem_rdata - 16'h0001;
              state_next = ITDE_WB_CNT;
            end
            ITDE_WB_CNT: begin
              state_next = ITDE_FINISH;
            end
            default: begin
              state_next = ITDE_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  // Timer of the current transfer, from the vector fetch onward
  itde_state_counter #(.WIDTH(8)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clr(state_reg == ITDE_WAIT_INSN),
    .count(elapsed)
  );

  // Completion flags and latch clearing, set wins over clear
  wire [15:0] idx_hot = 16'h0001 << idx_reg;
  // Request clear issued once the count write lands, at least one cycle before idle, so it cannot restart
  wire clr_go = (state_reg == ITDE_WB_CNT) && mem_reg.req && mem_ack;
  wire [15:0] clr_hot = clr_go ? idx_hot : 16'h0000;
  wire [15:0] done_set = (finish_go && (cnt_reg == 16'h0000)) ? idx_hot : 16'h0000;
  assign done_next = done_set | (done_reg & ~cpu_irq_ack);
  wire [1:0] pin_rise = ext_req_pin & ~pin_prev_reg;
  wire [1:0] latch_next = pin_rise | (latch_reg & ~clr_hot[1:0]);
  wire [15:0] cpu_irq_next = to_cpu | done_next;

  // Context save length reported to the CPU every cycle, from the control register
  wire [7:0] m8 = {6'h00, wait_m};
  wire [7:0] entry_next = ctrl_reg[`ITDE_CTRL_STK] ?
    (max_mode ? `ITDE_ENTRY_MAX_EXT + 8'(m8 * `ITDE_ENTRY_MAX_EXT_M)
              : `ITDE_ENTRY_MIN_EXT + 8'(m8 * `ITDE_ENTRY_MIN_EXT_M)) :
    (max_mode ? `ITDE_ENTRY_MAX_ON : `ITDE_ENTRY_MIN_ON);

  // Bus decode: address phase captured, write done in data phase
  wire bus_take = hsel && htrans[1] && hready;
  wire [7:0] rd_ofs = haddr[7:0];
  wire busy_w = (state_reg != ITDE_IDLE);
  wire [31:0] rd_value =
    (rd_ofs == `ITDE_OFS_CTRL) ? {26'h0000000, ctrl_reg} :
    (rd_ofs == `ITDE_OFS_ENABLE) ? {16'h0000, te_reg} :
    (rd_ofs == `ITDE_OFS_STATUS) ? {16'h0000, done_reg} | {24'h000000, idx_reg, 3'h0, busy_w} :
    (rd_ofs == `ITDE_OFS_XFERS) ? xfers_reg : 32'h00000000;
  wire ctrl_wr = bus_wr_reg && (bus_ofs_reg == `ITDE_OFS_CTRL);
  wire te_wr = bus_wr_reg && (bus_ofs_reg == `ITDE_OFS_ENABLE);

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ITDE_IDLE;
      mem_reg <= '0;
      cb_reg <= 16'h0000;
      mode_reg <= 16'h0000;
      src_reg <= 16'h0000;
      dst_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      data_reg <= 16'h0000;
      idx_reg <= 4'h0;
      prio_reg <= 2'd0;
      busy_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      mem_reg <= mem_next;
      cb_reg <= cb_next;
      mode_reg <= mode_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      cnt_reg <= cnt_next;
      data_reg <= data_next;
      idx_reg <= idx_next;
      prio_reg <= prio_next;
      busy_reg <= (state_next != ITDE_IDLE);
    end
  end

  // Request side registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_reg <= 16'h0000;
      cpu_irq_reg <= 16'h0000;
      latch_reg <= 2'b00;
      pin_prev_reg <= 2'b00;
      flag_clear_reg <= 14'h0000;
      entry_reg <= 8'h00;
      xfers_reg <= 32'h00000000;
    end else if (ce) begin
      done_reg <= done_next;
      cpu_irq_reg <= cpu_irq_next;
      latch_reg <= latch_next;
      pin_prev_reg <= ext_req_pin;
      flag_clear_reg <= clr_hot[15:2];
      entry_reg <= entry_next;
      xfers_reg <= finish_go ? xfers_reg + 32'h00000001 : xfers_reg;
    end
  end

  // Bus slave registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= 6'h00;
      te_reg <= 16'h0000;
      bus_wr_reg <= 1'b0;
      bus_ofs_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      ready_reg <= 1'b0;
    end else if (ce) begin
      ready_reg <= 1'b1;
      bus_wr_reg <= bus_take && hwrite;
      bus_ofs_reg <= haddr[7:0];
      hrdata_reg <= (bus_take && !hwrite) ? rd_value : hrdata_reg;
      ctrl_reg <= ctrl_wr ? hwdata[5:0] : ctrl_reg;
      te_reg <= te_wr ? hwdata[15:0] : te_reg;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = ready_reg;
  assign hresp = 1'b0;
  assign cpu_irq_req = cpu_irq_reg;
  assign cpu_entry_states = entry_reg;
  assign flag_clear = flag_clear_reg;
  assign mem_out = mem_reg;
  assign busy = busy_reg;

  // Checks
  sequence rd_done_s;
    (state_reg == ITDE_RD_DATA) && mem_reg.req && mem_ack;
  endsequence
  sequence cnt_load_s;
    (state_reg == ITDE_LD_CNT) && mem_reg.req && mem_ack;
  endsequence
  prio_wait_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(state_reg == ITDE_PRIO) |->
      (state_reg == ITDE_PRIO) [*2] ##1 (state_reg == ITDE_WAIT_INSN))
    else $error("priority decision not two states");
  cpu_route_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (to_cpu != 16'h0000) |=> ((cpu_irq_req & $past(to_cpu)) == $past(to_cpu)))
    else $error("disabled source not routed to cpu");
  vec_place_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (state_reg == ITDE_VEC && mem_reg.req) |->
      (max_mode ? (mem_reg.addr[1:0] == 2'b10 && mem_reg.addr[15:9] == 7'h00)
                : (mem_reg.addr[0] == 1'b0 && mem_reg.addr <= `ITDE_MIN_VEC_LAST)))
    else $error("vector entry address out of table");
  te_hold_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (busy && !te_wr) |=> $stable(te_reg))
    else $error("engine changed enable bits");
  cnt_dec_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    cnt_load_s |=> (cnt_reg == $past(mem_rdata) - 16'h0001) ##1
      (mem_reg.we && mem_reg.wdata == cnt_reg))
    else $error("count not decremented and written");
  inc_path_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    rd_done_s |=> (state_reg == (si ? ITDE_WB_SRC : ITDE_LD_DST)))
    else $error("source increment choice wrong");
  done_irq_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (finish_go && cnt_reg == 16'h0000) |=> cpu_irq_req[$past(idx_reg)])
    else $error("zero count did not interrupt cpu");
  flag_clr_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (clr_go && idx_reg >= 4'd2) |=>
      (flag_clear == $past(idx_hot[15:2])) ##1 (flag_clear == 14'h0000))
    else $error("flag clear pulse wrong");
  budget_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (state_reg == ITDE_FINISH && ({1'b0, elapsed} + 9'h001 < {1'b0, budget})) |=>
      (state_reg == ITDE_FINISH))
    else $error("transfer ended before its state count");
endmodule
`default_nettype wire

//--- itde_mem_model.sv
// Byte-wide page-0 memory answering the engine's access port.
// Assumes big-endian words and a one-cycle acknowledge pulse.
`timescale 1ns/1ps
`default_nettype none
module itde_mem_model import itde_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire itde_mem_req_t m,
  output logic [15:0] rdata,
  output logic ack
);
  logic [7:0] mem [0:65535];
  logic [1:0] dly;
  // Answer each held request after a random wait
  always @(posedge clk) begin
    ack <= 1'b0;
    if (!rst_n) begin
      dly <= 2'h0;
      rdata <= 16'h0000;
    end else if (m.req && !ack && dly != 2'h0) begin
      dly <= dly - 2'h1;
    end else if (m.req && !ack) begin
      ack <= 1'b1;
      dly <= 2'($urandom % 4);
      if (!m.we) begin
        rdata <= m.word ? {mem[m.addr], mem[m.addr + 16'h1]} : {~mem[m.addr], mem[m.addr]};
      end else if (m.word) begin
        mem[m.addr] <= m.wdata[15:8];
        mem[m.addr + 16'h1] <= m.wdata[7:0];
      end else begin
        mem[m.addr] <= m.wdata[7:0];
      end
    end else begin
      rdata <= ~rdata; // Released bus inverts its last data every cycle
    end
  end
endmodule
`default_nettype wire

//--- itde_pkg.sv
// Types shared by the transfer engine files.
// Assumes the constants header is compiled alongside.
package itde_pkg;
  typedef enum logic [3:0] {
    ITDE_IDLE = 4'b0000,
    ITDE_PRIO = 4'b0001,
    ITDE_WAIT_INSN = 4'b0010,
    ITDE_VEC = 4'b0011,
    ITDE_LD_MODE = 4'b0100,
    ITDE_LD_SRC = 4'b0101,
    ITDE_RD_DATA = 4'b0110,
    ITDE_WB_SRC = 4'b0111,
    ITDE_LD_DST = 4'b1000,
    ITDE_WR_DATA = 4'b1001,
    ITDE_WB_DST = 4'b1010,
    ITDE_LD_CNT = 4'b1011,
    ITDE_WB_CNT = 4'b1100,
    ITDE_FINISH = 4'b1101
  } itde_state_t;
  // One memory access request, held until acknowledged
  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } itde_mem_req_t;
endpackage

//--- itde_state_counter.sv
// Saturating state counter used to time one transfer.
// Assumes a synchronous active-low reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module itde_state_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  // Clear wins, otherwise count up and stop at all ones
  assign count_next = clr ? '0 : ((&count_reg) ? count_reg : count_reg + 1'b1);
  assign count = count_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire
